// ==== bench/core_model.sv ====
/*
 * Behavioural core sequencer: one-cycle instructions, acknowledges offers.
 * Assumes the bench steers acknowledge, its delay and returns.
 */
`timescale 1ns/100ps
module core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Controller side
    input wire intc_pkg::call_t call_i,
    input wire logic busy_i,
    output logic instr_done_o,
    output logic return_from_int_instr_done_o,
    output logic call_ack_o,
    // Scenario control
    input wire logic ack_en_i,
    input wire logic [1:0] ack_wait_i,
    input wire logic return_from_int_instr_req_i
);
    logic [1:0] wait_cnt;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_cnt <= 2'h0;
            call_ack_o <= 1'b0;
        end else begin
            call_ack_o <= 1'b0;
            if (!call_i.valid || call_ack_o || busy_i) begin
                wait_cnt <= 2'h0;
            end else if (ack_en_i && wait_cnt == ack_wait_i) begin
                call_ack_o <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
    // Return and ordinary instructions never end in the same cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            return_from_int_instr_done_o <= 1'b0;
            instr_done_o <= 1'b0;
        end else begin
            return_from_int_instr_done_o <= return_from_int_instr_req_i;
            instr_done_o <= !return_from_int_instr_req_i && !busy_i && !call_ack_o;
        end
    end
endmodule // core_model

// ==== bench/int_controller_sva.sv ====
/*
 * Port-level checker for the interrupt controller top module.
 * Assumes it is bound into every int_controller instance.
 */
`timescale 1ns/100ps
module int_controller_sva #(
    parameter logic [intc_pkg::VEC_W-1:0] VECTOR_BASE = 16'h0003,
    parameter logic [intc_pkg::VEC_W-1:0] VECTOR_STEP = 16'h0008
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Watched ports
    input wire intc_pkg::sfr_req_t sfr_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sfr_hit_o,
    input wire logic [intc_pkg::NUM_SRC-1:0] pend_o,
    input wire logic [intc_pkg::NUM_SRC-1:0] vec_clr_o,
    input wire logic return_from_int_instr_done_i,
    input wire logic call_ack_i,
    input wire intc_pkg::call_t call_o,
    input wire logic [1:0] in_service_o,
    input wire logic call_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic take;
    logic mapped;
    logic [1:0] off_cnt;
    assign take = call_ack_i && call_o.valid;
    assign mapped = sfr_i.addr inside {intc_pkg::INT_ENABLE_ADDR, intc_pkg::INT_PRIORITY_ADDR,
        intc_pkg::EXT_ENABLE_ADDR, intc_pkg::EXT_PRIORITY_ADDR};
    // Cycles since global enable was written low, saturating at 2
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            off_cnt <= 2'h2;
        end else if (sfr_i.wr && sfr_i.addr == intc_pkg::INT_ENABLE_ADDR) begin
            off_cnt <= sfr_i.wdata[7] ? 2'h0 : 2'h1;
        end else if (off_cnt == 2'h1) begin
            off_cnt <= 2'h2;
        end
    end
    offer_drop_a: assert property (take |=> !call_o.valid)
        else $error("offer still up after acknowledge");
    call_len_a: assert property (take |=> call_busy_o [*4] ##1 !call_busy_o)
        else $error("long call not four cycles");
    vec_clear_a: assert property (take |=> vec_clr_o == (15'h0001 << $past(call_o.src)))
        else $error("vector clear pulse wrong");
    global_off_a: assert property (off_cnt == 2'h2 |-> !call_o.valid)
        else $error("offer with global enable low");
    flag_source_a: assert property (call_o.valid |-> pend_o[call_o.src])
        else $error("offer without pending flag");
    vector_map_a: assert property (call_o.valid |->
        call_o.vector == VECTOR_BASE + VECTOR_STEP * call_o.src)
        else $error("vector address wrong");
    high_block_a: assert property (in_service_o[1] |-> !call_o.valid)
        else $error("offer during high routine");
    low_level_a: assert property (in_service_o[0] && call_o.valid |->
        call_o.level == intc_pkg::LEVEL_HIGH)
        else $error("low offer during low routine");
    return_hold_a: assert property (return_from_int_instr_done_i |=> ##1 !call_o.valid)
        else $error("offer too soon after return");
    unmapped_rd_a: assert property (sfr_i.rd && !mapped |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
        else $error("unmapped read answered");
    prio_top_a: assert property (sfr_i.rd && sfr_i.addr == intc_pkg::INT_PRIORITY_ADDR |=>
        sfr_hit_o && !sfr_rdata_o[7])
        else $error("priority read wrong");
    cover property (take && call_o.level == intc_pkg::LEVEL_HIGH);
    cover property (in_service_o == 2'b11);
    cover property (return_from_int_instr_done_i ##[1:6] call_o.valid);
endmodule // int_controller_sva

bind int_controller int_controller_sva #(.VECTOR_BASE(VECTOR_BASE), .VECTOR_STEP(VECTOR_STEP))
    sva_u (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
    .sfr_hit_o(sfr_hit_o), .pend_o(pend_o), .vec_clr_o(vec_clr_o), .return_from_int_instr_done_i(return_from_int_instr_done_i),
    .call_ack_i(call_ack_i), .call_o(call_o), .in_service_o(in_service_o),
    .call_busy_o(call_busy_o));

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench for the interrupt controller with a core model.
 * Assumes the checker is bound in from its own file.
 */
`timescale 1ns/100ps
module tb_top;
    localparam logic [15:0] VB = 16'h0003;
    localparam logic [15:0] VS = 16'h0008;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    intc_pkg::sfr_req_t sfr = '0;
    logic [14:0] hw_event = '0;
    logic [14:0] sw_set = '0;
    logic [14:0] sw_clr = '0;
    logic ack_en = 1'b0;
    logic [1:0] ack_wait = 2'h0;
    logic return_from_int_instr_req = 1'b0;
    logic [7:0] rdata;
    logic hit;
    logic [14:0] pend;
    logic [14:0] vec_clr;
    logic instr_done;
    logic return_from_int_instr_done;
    logic call_ack;
    intc_pkg::call_t call;
    logic [1:0] in_srv;
    logic busy;
    logic [7:0] map [4] = '{8'hA8, 8'hB8, 8'hE6, 8'hF3};
    int errors = 0;
    int tests_run = 0;

    always #4 clk_i = ~clk_i;

    int_controller #(.VECTOR_BASE(VB), .VECTOR_STEP(VS)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .sfr_i(sfr), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .hw_event_i(hw_event),
        .sw_set_i(sw_set), .sw_clr_i(sw_clr), .pend_o(pend), .vec_clr_o(vec_clr),
        .instr_done_i(instr_done), .return_from_int_instr_done_i(return_from_int_instr_done), .call_ack_i(call_ack),
        .call_o(call), .in_service_o(in_srv), .call_busy_o(busy));
    core_model core_u (.clk_i(clk_i), .nrst_i(nrst_i), .call_i(call), .busy_i(busy),
        .instr_done_o(instr_done), .return_from_int_instr_done_o(return_from_int_instr_done), .call_ack_o(call_ack),
        .ack_en_i(ack_en), .ack_wait_i(ack_wait), .return_from_int_instr_req_i(return_from_int_instr_req));

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait for an offer (0) or a running long call (1)
    task automatic wait_on(input bit which);
        int i;
        for (i = 0; i < 24 && (which ? busy : call.valid) !== 1'b1; i++) tick();
        if (i == 24) begin
            check("wait limit", 16'h0, 16'h1);
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        tick();
        sfr = '0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
        sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        tick();
        check("read data", rdata, exp);
        check("read hit", hit, exp_hit);
        sfr = '0;
        tick();
    endtask
    task automatic flags(input logic [14:0] set, input logic [14:0] clr);
        sw_set = set;
        sw_clr = clr;
        tick();
        sw_set = '0;
        sw_clr = '0;
    endtask
    task automatic serve(input logic [3:0] src, input intc_pkg::level_t lvl);
        wait_on(1'b0);
        check("offer source", call.src, src);
        check("offer level", call.level, lvl);
        ack_en = 1'b1;
        wait_on(1'b1);
        ack_en = 1'b0;
        check("vector clear", vec_clr, 15'h0001 << src);
        tick(5);
    endtask
    task automatic ret();
        return_from_int_instr_req = 1'b1;
        tick();
        return_from_int_instr_req = 1'b0;
        tick(3);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            rd(map[i], 8'h00, 1'b1);
            wr(map[i], 8'hD5);
            rd(map[i], i == 1 ? 8'h55 : 8'hD5, 1'b1);
            wr(map[i], 8'h00);
        end
        wr(8'hA9, 8'hFF);
        rd(8'hA9, 8'h00, 1'b0);
        $display("Test registers done");
    endtask
    task automatic t_basic();
        wr(intc_pkg::INT_ENABLE_ADDR, 8'h80);
        wr(intc_pkg::EXT_ENABLE_ADDR, 8'h04);
        hw_event = 15'h0200;
        tick();
        hw_event = '0;
        check("detect cycle", call.valid, 1'b0);
        tick();
        check("offer cycle", call.valid, 1'b1);
        check("offer vector", call.vector, VB + VS * 16'd9);
        ack_wait = 2'h2;
        serve(4'd9, intc_pkg::LEVEL_LOW);
        ack_wait = 2'h0;
        check("flag kept", pend[9], 1'b1);
        check("low routine", in_srv, 2'b01);
        check("no low preempt", call.valid, 1'b0);
        return_from_int_instr_req = 1'b1;
        tick();
        return_from_int_instr_req = 1'b0;
        wait_on(1'b0);
        check("reentry source", call.src, 4'd9);
        flags('0, 15'h0200);
        tick(2);
        check("flag cleared", pend[9], 1'b0);
        check("offer gone", call.valid, 1'b0);
        wr(intc_pkg::EXT_ENABLE_ADDR, 8'h00);
        $display("Test basic call done");
    endtask
    task automatic t_mask();
        wr(intc_pkg::INT_ENABLE_ADDR, 8'h08);
        hw_event = 15'h0008;
        tick();
        hw_event = '0;
        tick(3);
        check("flag while disabled", pend[3], 1'b1);
        check("offer global off", call.valid, 1'b0);
        wr(intc_pkg::INT_ENABLE_ADDR, 8'h80);
        tick(3);
        check("offer source off", call.valid, 1'b0);
        wr(intc_pkg::INT_ENABLE_ADDR, 8'h88);
        tick(2);
        check("offer both on", call.valid, 1'b1);
        flags('0, 15'h0008);
        tick(3);
        flags(15'h0008, '0);
        tick(2);
        check("software set offer", call.valid, 1'b1);
        flags('0, 15'h0008);
        wr(intc_pkg::INT_ENABLE_ADDR, 8'h00);
        $display("Test masking done");
    endtask
    task automatic t_prio();
        wr(intc_pkg::INT_ENABLE_ADDR, 8'hA2);
        wr(intc_pkg::INT_PRIORITY_ADDR, 8'h20);
        flags(15'h0022, '0);
        serve(4'd5, intc_pkg::LEVEL_HIGH);
        check("no preempt of high", call.valid, 1'b0);
        flags('0, 15'h0020);
        ret();
        serve(4'd1, intc_pkg::LEVEL_LOW);
        flags(15'h0020, '0);
        serve(4'd5, intc_pkg::LEVEL_HIGH);
        check("nested levels", in_srv, 2'b11);
        flags('0, 15'h0022);
        ret();
        ret();
        wr(intc_pkg::INT_PRIORITY_ADDR, 8'h00);
        flags(15'h0022, '0);
        serve(4'd1, intc_pkg::LEVEL_LOW);
        flags('0, 15'h0022);
        ret();
        wr(intc_pkg::INT_ENABLE_ADDR, 8'h00);
        $display("Test priority done");
    endtask

    initial begin
        tick(4);
        nrst_i = 1'b1;
        tick(4);
        t_regs();
        t_basic();
        t_mask();
        t_prio();
        conclude();
    end
endmodule // tb_top

// ==== common/intc_pkg.sv ====
/*
 * Shared constants and carrier types for the two-level interrupt controller.
 * Assumes an 8-bit special function register bus inside the device and a
 * processor core that reports instruction boundaries and acknowledges calls.
 */
package intc_pkg;

    // Register addresses on the special function register bus
    localparam logic [7:0] INT_ENABLE_ADDR = 8'hA8;
    localparam logic [7:0] INT_PRIORITY_ADDR = 8'hB8;
    localparam logic [7:0] EXT_ENABLE_ADDR = 8'hE6;
    localparam logic [7:0] EXT_PRIORITY_ADDR = 8'hF3;

    // Reset values: everything disabled, every source low priority
    localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] INT_PRIORITY_RESET = 8'h00;
    localparam logic [7:0] EXT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] EXT_PRIORITY_RESET = 8'h00;

    // Field layout
    localparam int GLOBAL_ENABLE_BIT = 7;
    localparam int BASE_SRC_COUNT = 7;
    localparam int EXT_SRC_COUNT = 8;
    localparam int NUM_SRC = BASE_SRC_COUNT + EXT_SRC_COUNT;
    localparam int SRC_W = 4;
    localparam int VEC_W = 16;

    // Response timing in system clock cycles
    localparam int DETECT_CYCLES = 1;
    localparam int LONG_CALL_INSTR_CYCLES = 4;
    localparam int RETURN_FROM_INT_INSTR_CYCLES = 5;
    localparam int DIV_CYCLES = 8;
    localparam int RESP_MIN_CYCLES = DETECT_CYCLES + LONG_CALL_INSTR_CYCLES;
    localparam int RESP_MAX_CYCLES = DETECT_CYCLES + RETURN_FROM_INT_INSTR_CYCLES + DIV_CYCLES + LONG_CALL_INSTR_CYCLES;

    typedef enum logic [0:0] {
        LEVEL_LOW = 1'b0,
        LEVEL_HIGH = 1'b1
    } level_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic valid;
        level_t level;
        logic [SRC_W-1:0] src;
        logic [VEC_W-1:0] vector;
    } call_t;

endpackage

// ==== hw/int_controller.sv ====
/*
 * Two-level vectored interrupt controller with its enable and priority
 * registers on the special function register bus.
 * Assumes the core pulses instr_done_i at each instruction boundary,
 * return_from_int_instr_done_i when a return-from-interrupt completes, and call_ack_i in the
 * cycle it starts the long call for the offered request.
 */
`timescale 1ns/100ps

// Operation
// RULE1: Flag sets on event regardless of enable
// RULE2: Enabled pending flag offers vectored long call
// RULE3: Disabled sources never vector
// RULE4: Per-source enables count only under global enable
// RULE5: Global enable low blocks all requests
// RULE6: Some flags auto-clear on vector, others software
// RULE7: Flag still set after return requests again
// RULE8: Routine ends with return; core resumes flow
// RULE9: Software flag set acts like hardware event
// RULE10: High preempts low; nothing preempts high
// RULE11: Priority bit per source; reset low
// RULE12: Same cycle: higher level, then fixed order
// RULE13: Sample and decode requests every cycle
// RULE14: Fastest response five cycles: detect plus call
// RULE15: One instruction runs after return before call
// RULE16: Worst unnested response eighteen cycles
// RULE17: Vectors and same-level order are parameters
module int_controller #(
    parameter int NUM = intc_pkg::NUM_SRC,
    parameter logic [intc_pkg::VEC_W-1:0] VECTOR_BASE = 16'h0003,
    parameter logic [intc_pkg::VEC_W-1:0] VECTOR_STEP = 16'h0008,
    parameter logic [NUM*intc_pkg::SRC_W-1:0] PICK_ORDER =
        60'hEDCBA9876543210,
    parameter logic [NUM-1:0] HW_CLEAR_MASK = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Special function register bus
    input wire intc_pkg::sfr_req_t sfr_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    // Peripheral flag sources
    input wire logic [NUM-1:0] hw_event_i,
    input wire logic [NUM-1:0] sw_set_i,
    input wire logic [NUM-1:0] sw_clr_i,
    output logic [NUM-1:0] pend_o,
    output logic [NUM-1:0] vec_clr_o,
    // Core sequencer
    input wire logic instr_done_i,
    input wire logic return_from_int_instr_done_i,
    input wire logic call_ack_i,
    output intc_pkg::call_t call_o,
    output logic [1:0] in_service_o,
    output logic call_busy_o
);

    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] LONG_CALL_INSTR_COUNT = CNT_W'(intc_pkg::LONG_CALL_INSTR_CYCLES);

    logic rst_meta;
    logic rst_n;

    logic [7:0] int_enable_reg;
    logic [7:0] int_priority_reg;
    logic [7:0] extended_enable_reg;
    logic [7:0] extended_priority_reg;

    logic [NUM-1:0] pend;
    logic [NUM-1:0] vec_clr;
    logic global_int_enable;
    logic [NUM-1:0] src_enable;
    logic [NUM-1:0] src_high;
    logic [NUM-1:0] eligible;

    logic win_valid;
    intc_pkg::level_t win_level;
    logic [intc_pkg::SRC_W-1:0] win_src;

    logic active_high;
    logic active_low;
    logic return_from_int_instr_hold;
    logic [CNT_W-1:0] long_call_instr_cnt;
    logic call_taken;
    logic offer_ok;

    // Reset release through two flip-flops
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Vector address of a source
    function automatic logic [intc_pkg::VEC_W-1:0] vector_of(
        input logic [intc_pkg::SRC_W-1:0] src);
        logic [31:0] prod;
        prod = 32'(src) * 32'(VECTOR_STEP);
        return VECTOR_BASE + prod[intc_pkg::VEC_W-1:0]; // see RULE17
    endfunction

    // Register write decode
    function automatic logic sfr_write_to(input intc_pkg::sfr_req_t req,
                                          input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction

    // Enable registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_enable_reg <= intc_pkg::INT_ENABLE_RESET;
            extended_enable_reg <= intc_pkg::EXT_ENABLE_RESET;
        end else begin
            if (sfr_write_to(sfr_i, intc_pkg::INT_ENABLE_ADDR)) begin
                int_enable_reg <= sfr_i.wdata;
            end
            if (sfr_write_to(sfr_i, intc_pkg::EXT_ENABLE_ADDR)) begin
                extended_enable_reg <= sfr_i.wdata;
            end
        end
    end

    // Priority registers; every source starts at low priority
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_priority_reg <= intc_pkg::INT_PRIORITY_RESET; // see RULE11
            extended_priority_reg <= intc_pkg::EXT_PRIORITY_RESET; // see RULE11
        end else begin
            if (sfr_write_to(sfr_i, intc_pkg::INT_PRIORITY_ADDR)) begin
                int_priority_reg <= {1'b0, sfr_i.wdata[intc_pkg::BASE_SRC_COUNT-1:0]};
            end
            if (sfr_write_to(sfr_i, intc_pkg::EXT_PRIORITY_ADDR)) begin
                extended_priority_reg <= sfr_i.wdata;
            end
        end
    end

    // Register read port, answered one cycle after the read strobe
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o <= 1'b0;
        end else if (sfr_i.rd) begin
            sfr_hit_o <= 1'b1;
            if (sfr_i.addr == intc_pkg::INT_ENABLE_ADDR) begin
                sfr_rdata_o <= int_enable_reg;
            end else if (sfr_i.addr == intc_pkg::INT_PRIORITY_ADDR) begin
                sfr_rdata_o <= int_priority_reg;
            end else if (sfr_i.addr == intc_pkg::EXT_ENABLE_ADDR) begin
                sfr_rdata_o <= extended_enable_reg;
            end else if (sfr_i.addr == intc_pkg::EXT_PRIORITY_ADDR) begin
                sfr_rdata_o <= extended_priority_reg;
            end else begin
                sfr_rdata_o <= 8'h00;
                sfr_hit_o <= 1'b0;
            end
        end else begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o <= 1'b0;
        end
    end

    // Pending flags keep state whatever the enables say
    pending_flags #(
        .NUM(NUM),
        .HW_CLEAR_MASK(HW_CLEAR_MASK)
    ) u_pending (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .hw_event_i(hw_event_i),
        .sw_set_i(sw_set_i),
        .sw_clr_i(sw_clr_i),
        .vec_clr_i(vec_clr),
        .pend_o(pend)
    );

    // Enable gating
    always_comb begin
        global_int_enable = int_enable_reg[intc_pkg::GLOBAL_ENABLE_BIT];
        src_enable = {extended_enable_reg,
                      int_enable_reg[intc_pkg::BASE_SRC_COUNT-1:0]}; // see RULE4
        src_high = {extended_priority_reg,
                    int_priority_reg[intc_pkg::BASE_SRC_COUNT-1:0]}; // see RULE11
        eligible = pend & src_enable & {NUM{global_int_enable}}; // see RULE3 see RULE5
    end

    // Preemption: high needs no high routine running, low needs none at all
    priority_arbiter #(
        .NUM(NUM),
        .PICK_ORDER(PICK_ORDER)
    ) u_arbiter (
        .req_i(eligible),
        .high_i(src_high),
        .allow_high_i(!active_high), // see RULE10
        .allow_low_i(!active_high && !active_low), // see RULE10
        .valid_o(win_valid),
        .level_o(win_level),
        .src_o(win_src)
    );

    always_comb begin
        call_taken = call_ack_i && call_o.valid;
        offer_ok = !return_from_int_instr_hold && (long_call_instr_cnt == '0) && !call_taken; // see RULE15
    end

    // Detection stage: the winner is resampled every cycle into the offer
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            call_o <= '0;
        end else begin
            call_o.valid <= win_valid && offer_ok; // see RULE2 see RULE13 see RULE14
            call_o.level <= win_level; // see RULE12
            call_o.src <= win_src;
            call_o.vector <= vector_of(win_src); // see RULE2
        end
    end

    // Long call in flight: no new offer until it has completed
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            long_call_instr_cnt <= '0;
        end else if (call_taken) begin
            long_call_instr_cnt <= LONG_CALL_INSTR_COUNT; // see RULE14
        end else if (long_call_instr_cnt != '0) begin
            long_call_instr_cnt <= long_call_instr_cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            call_busy_o <= 1'b0;
        end else begin
            call_busy_o <= call_taken || (long_call_instr_cnt > CNT_W'(1));
        end
    end

    // Hardware clear pulse for the vectored source
    always_comb begin
        vec_clr = '0;
        if (call_taken) begin
            vec_clr[call_o.src] = 1'b1; // see RULE6
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            vec_clr_o <= '0;
        end else begin
            vec_clr_o <= vec_clr;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_o <= '0;
        end else begin
            pend_o <= pend;
        end
    end

    // Routine levels in service; a call sets, a return clears the innermost
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            active_high <= 1'b0;
            active_low <= 1'b0;
        end else begin
            if (return_from_int_instr_done_i) begin
                if (active_high) begin
                    active_high <= 1'b0; // see RULE8
                end else begin
                    active_low <= 1'b0;
                end
            end
            if (call_taken) begin
                if (call_o.level == intc_pkg::LEVEL_HIGH) begin
                    active_high <= 1'b1; // see RULE10
                end else begin
                    active_low <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_service_o <= 2'b00;
        end else begin
            in_service_o <= {active_high, active_low};
        end
    end

    // After a return one further instruction must complete before a call
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            return_from_int_instr_hold <= 1'b0;
        end else if (return_from_int_instr_done_i) begin
            return_from_int_instr_hold <= 1'b1; // see RULE7 see RULE15 see RULE16
        end else if (instr_done_i) begin
            return_from_int_instr_hold <= 1'b0; // see RULE7
        end
    end

endmodule // int_controller

// ==== hw/pending_flags.sv ====
/*
 * Interrupt-pending flags, one per source.
 * Assumes set and clear vectors are synchronous to clk_i; a set in the
 * same cycle as any clear leaves the flag set.
 */
`timescale 1ns/100ps
module pending_flags #(
    parameter int NUM = intc_pkg::NUM_SRC,
    parameter logic [NUM-1:0] HW_CLEAR_MASK = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Set sources
    input wire logic [NUM-1:0] hw_event_i,
    input wire logic [NUM-1:0] sw_set_i,
    // Clear sources
    input wire logic [NUM-1:0] sw_clr_i,
    input wire logic [NUM-1:0] vec_clr_i,
    // Flags
    output logic [NUM-1:0] pend_o
);

    logic [NUM-1:0] next_pend;

    always_comb begin
        next_pend = pend_o & ~(sw_clr_i | (vec_clr_i & HW_CLEAR_MASK)); // see RULE6
        next_pend = next_pend | hw_event_i | sw_set_i; // see RULE1 see RULE9
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_o <= '0;
        end else begin
            pend_o <= next_pend;
        end
    end

endmodule // pending_flags

// ==== hw/priority_arbiter.sv ====
/*
 * Two-level fixed-order arbiter over eligible requests.
 * Assumes PICK_ORDER lists each source index once, first entry winning.
 */
`timescale 1ns/100ps
module priority_arbiter #(
    parameter int NUM = intc_pkg::NUM_SRC,
    parameter logic [NUM*intc_pkg::SRC_W-1:0] PICK_ORDER = '0
) (
    // Requests
    input wire logic [NUM-1:0] req_i,
    input wire logic [NUM-1:0] high_i,
    input wire logic allow_high_i,
    input wire logic allow_low_i,
    // Winner
    output logic valid_o,
    output intc_pkg::level_t level_o,
    output logic [intc_pkg::SRC_W-1:0] src_o
);

    logic [NUM-1:0] hi_req;
    logic [NUM-1:0] lo_req;
    logic hi_any;
    logic lo_any;
    logic [intc_pkg::SRC_W-1:0] hi_src;
    logic [intc_pkg::SRC_W-1:0] lo_src;

    // Walk the order from last to first so the earliest listed source wins
    function automatic logic [intc_pkg::SRC_W:0] pick(input logic [NUM-1:0] r);
        logic [intc_pkg::SRC_W-1:0] idx;
        logic [intc_pkg::SRC_W:0] res;
        res = '0;
        for (int i = NUM - 1; i >= 0; i--) begin
            idx = PICK_ORDER[i*intc_pkg::SRC_W +: intc_pkg::SRC_W];
            if (r[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction

    always_comb begin
        hi_req = req_i & high_i & {NUM{allow_high_i}}; // see RULE10
        lo_req = req_i & ~high_i & {NUM{allow_low_i}};
        {hi_any, hi_src} = pick(hi_req); // see RULE12
        {lo_any, lo_src} = pick(lo_req);
        valid_o = hi_any | lo_any;
        level_o = hi_any ? intc_pkg::LEVEL_HIGH : intc_pkg::LEVEL_LOW; // see RULE12
        src_o = hi_any ? hi_src : lo_src;
    end

endmodule // priority_arbiter
